// File: vsg_pkg.sv
package vsg_pkg;

	// ----------------------------------------
	// Opcodes and sub-operation bit positions
	// ----------------------------------------
	localparam logic [7:0] SCATTER_OPCODE      = 8'hB7;
	localparam logic [7:0] GATHER_OPCODE       = 8'hBA;
	localparam logic [7:0] REVERSE_COPY_OPCODE = 8'hB8;
	localparam int         G_HALF              = 0;
	localparam int         G_BCAST             = 4;
	localparam int         G_FIXED             = 5;
	localparam int         G_GROUP             = 6;
	localparam int         G_RFILE             = 7;

	// ----------------------------------------
	// Register field layout and shifts
	// ----------------------------------------
	localparam int         AW                  = 48;
	localparam int         LEN_LSB             = 48;
	localparam logic [2:0] SH32                = 3'h5;
	localparam logic [2:0] SH64                = 3'h6;
	localparam logic [47:0] RF_TOP             = 48'h3FC0;

	// Instruction as handed over by the sequencer.
	typedef struct packed {
		logic [7:0]  op;
		logic [7:0]  subop;
		logic [63:0] reg_a;
		logic [63:0] reg_b;
		logic [63:0] reg_c;
	} cmd_t;

	// One destination write.
	typedef struct packed {
		logic        rf;
		logic        half;
		logic [47:0] addr;
		logic [63:0] data;
	} wr_t;

endpackage : vsg_pkg

// File: vector_scatter_gather.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) Scatter writes group at base plus index.
// (R2) Gather reads indexed groups, stores them consecutively.
// (R3) Index elements 64-bit; data per bit 0.
// (R4) Shift item count 5 or 6 places.
// (R5) Bit 5 uses fixed increment, count N.
// (R6) Program zeroes index offset for increment mode.
// (R7) Program zeroes offset and control designators.
// (R8) No field lengths; equal groups; index ends.
// (R9) Bit 6 clear: one element per group.
// (R10) Bit 6 set: size field; zero is no-op.
// (R11) Scatter ignores destination upper bits otherwise.
// (R12) Gather ignores source upper bits otherwise.
// (R13) Scatter bit 4 broadcasts; never with bit 6.
// (R14) Scatter bit 7 targets register file space.
// (R15) Program avoids bits 6+7 and bits 1-3.
// (R16) Gather never broadcasts any operand.
// (R17) Reverse copy writes last source first.
// (R18) Reverse stops at result end, zero-fills.
// (R19) Program keeps reverse areas apart, bits zero.
// (R20) Overlapping reverse areas give undefined results.
// (R21) Done only after final write accepted.

// ----------------------------------------
// Write buffer
// ----------------------------------------
module vsg_fifo #(
	parameter int W     = 114,
	parameter int DEPTH = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [PW:0]  wp;
	logic [PW:0]  rp;
	logic [PW:0]  next_wp;
	logic [PW:0]  next_rp;

	// Full and empty from pointers with a wrap bit.
	assign out_valid = (wp != rp);
	assign in_ready  = (wp[PW-1:0] != rp[PW-1:0]) || (wp[PW] == rp[PW]);
	assign out_data  = mem[rp[PW-1:0]];

	// Pointer advance on each handshake.
	always_comb begin
		next_wp = wp;
		next_rp = rp;
		if (in_valid && in_ready) begin
			next_wp = wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			next_rp = rp + 1'b1;
		end
	end

	// Pointer and storage registers.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
		end
		if (in_valid && in_ready) begin
			mem[wp[PW-1:0]] <= in_data;
		end
	end
endmodule : vsg_fifo

// ----------------------------------------
// Scatter, gather and reverse-copy engine
// ----------------------------------------
module vector_scatter_gather #(
	parameter int DEPTH = 8
) (
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire logic          start,
	input  wire vsg_pkg::cmd_t cmd,
	output logic               busy,
	output logic               done,
	output logic               rd_valid,
	input  wire logic          rd_ready,
	output logic [47:0]        rd_addr,
	input  wire logic          rvalid,
	input  wire logic [63:0]   rdata,
	output logic               wr_valid,
	input  wire logic          wr_ready,
	output vsg_pkg::wr_t       wr
);
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_IDXR = 8'h02,
		S_IDXW = 8'h04,
		S_ELEM = 8'h08,
		S_SRCR = 8'h10,
		S_SRCW = 8'h20,
		S_PUSH = 8'h40,
		S_DRN  = 8'h80
	} state_t;

	state_t        state, next_state;
	vsg_pkg::cmd_t c, next_c;
	logic [15:0]   grp, next_grp, k, next_k, ng;
	logic [31:0]   outn, next_outn;
	logic [47:0]   idx, next_idx, raddr, next_raddr;
	logic [47:0]   dst, next_dst, src_a, dst_a;
	logic [63:0]   data, next_data;
	logic          next_done, go;
	logic          is_sc, is_ga, is_rv, half, bcast;
	logic [2:0]    esh;
	logic [15:0]   n_grp, g_size, la;
	logic [47:0]   off, on;
	logic          f_ready;
	vsg_pkg::wr_t  f_in;

	// Group count: index length, or result length when reversing.
	function automatic logic [15:0] count_of(vsg_pkg::cmd_t x);
		if (x.op == vsg_pkg::REVERSE_COPY_OPCODE) begin
			return x.reg_c[63:vsg_pkg::LEN_LSB]; // see (R18)
		end
		return x.reg_a[63:vsg_pkg::LEN_LSB]; // see (R5) see (R8)
	endfunction : count_of

	// Group size: one, or the upper field of the ruling register.
	function automatic logic [15:0] size_of(vsg_pkg::cmd_t x);
		if (x.op == vsg_pkg::REVERSE_COPY_OPCODE || !x.subop[vsg_pkg::G_GROUP]) begin
			return 16'h0001; // see (R9)
		end
		if (x.op == vsg_pkg::SCATTER_OPCODE) begin
			return x.reg_c[63:vsg_pkg::LEN_LSB]; // see (R10) see (R11)
		end
		return x.reg_b[63:vsg_pkg::LEN_LSB]; // see (R12)
	endfunction : size_of

	// Decoded view of the latched instruction.
	assign is_sc  = (c.op == vsg_pkg::SCATTER_OPCODE);
	assign is_ga  = (c.op == vsg_pkg::GATHER_OPCODE);
	assign is_rv  = (c.op == vsg_pkg::REVERSE_COPY_OPCODE);
	assign half   = c.subop[vsg_pkg::G_HALF];
	assign esh    = half ? vsg_pkg::SH32 : vsg_pkg::SH64; // see (R3) see (R4)
	assign bcast  = is_sc && c.subop[vsg_pkg::G_BCAST]; // see (R13) see (R16)
	assign n_grp  = count_of(c);
	assign g_size = size_of(c);
	assign la     = c.reg_a[63:vsg_pkg::LEN_LSB];

	// Element addresses from index, element and output counters.
	assign off   = (idx << esh) + (48'(k) << esh); // see (R4)
	assign on    = 48'(outn) << esh;
	assign src_a = is_rv ? c.reg_a[47:0] + (48'(la - 16'h0001 - grp) << esh) // see (R17)
	             : is_ga ? c.reg_b[47:0] + off : c.reg_b[47:0] + on; // see (R2)
	assign dst_a = is_sc ? c.reg_c[47:0] + off : c.reg_c[47:0] + on; // see (R1) see (R2)

	// Sequencer next-state logic.
	always_comb begin
		next_state = state;
		next_c     = c;
		next_grp   = grp;
		next_k     = k;
		next_outn  = outn;
		next_idx   = idx;
		next_raddr = raddr;
		next_dst   = dst;
		next_data  = data;
		next_done  = 1'b0;
		go         = 1'b0;
		ng         = grp;
		unique case (state)
			S_IDLE: begin
				if (start) begin
					next_c    = cmd;
					next_grp  = '0;
					ng        = '0; // First group addresses from element zero, not the last group of the prior instruction.
					next_k    = '0;
					next_outn = '0;
					if (cmd.op != vsg_pkg::SCATTER_OPCODE && cmd.op != vsg_pkg::GATHER_OPCODE
					    && cmd.op != vsg_pkg::REVERSE_COPY_OPCODE) begin
						next_state = S_DRN;
					end else if (count_of(cmd) == 16'h0000 || size_of(cmd) == 16'h0000) begin
						next_state = S_DRN; // see (R10)
					end else begin
						go = 1'b1;
					end
				end
			end
			S_IDXR: begin
				if (rd_ready) begin
					next_state = S_IDXW;
				end
			end
			S_IDXW: begin
				if (rvalid) begin
					next_idx   = rdata[47:0]; // see (R1) see (R3)
					next_state = S_ELEM;
				end
			end
			S_ELEM: begin
				next_raddr = src_a;
				next_dst   = dst_a;
				if (bcast) begin
					next_data  = half ? {32'h0, c.reg_b[31:0]} : c.reg_b; // see (R13)
					next_state = S_PUSH;
				end else if (is_rv && grp >= la) begin
					next_data  = '0; // see (R18)
					next_state = S_PUSH;
				end else begin
					next_state = S_SRCR;
				end
			end
			S_SRCR: begin
				if (rd_ready) begin
					next_state = S_SRCW;
				end
			end
			S_SRCW: begin
				if (rvalid) begin
					next_data  = half ? {32'h0, rdata[31:0]} : rdata; // see (R3)
					next_state = S_PUSH;
				end
			end
			S_PUSH: begin
				if (f_ready) begin
					next_outn = outn + 32'h1;
					if (k == g_size - 16'h0001) begin
						next_k = '0;
						if (grp == n_grp - 16'h0001) begin
							next_state = S_DRN; // see (R8) see (R18)
						end else begin
							ng       = grp + 16'h0001;
							next_grp = ng;
							go       = 1'b1;
						end
					end else begin
						next_k     = k + 16'h0001;
						next_state = S_ELEM;
					end
				end
			end
			S_DRN: begin
				if (!wr_valid) begin
					next_done  = 1'b1; // see (R21)
					next_state = S_IDLE;
				end
			end
		endcase
		if (go) begin
			if (next_c.op != vsg_pkg::REVERSE_COPY_OPCODE && !next_c.subop[vsg_pkg::G_FIXED]) begin
				next_raddr = next_c.reg_a[47:0] + (48'(ng) << vsg_pkg::SH64); // see (R3)
				next_state = S_IDXR;
			end else begin
				next_idx   = 48'(next_c.reg_a[47:0] * ng); // see (R5)
				next_state = S_ELEM;
			end
		end
	end

	// Sequencer registers.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= S_IDLE;
			c     <= '0;
			grp   <= '0;
			k     <= '0;
			outn  <= '0;
			idx   <= '0;
			raddr <= '0;
			dst   <= '0;
			data  <= '0;
			done  <= 1'b0;
		end else begin
			state <= next_state;
			c     <= next_c;
			grp   <= next_grp;
			k     <= next_k;
			outn  <= next_outn;
			idx   <= next_idx;
			raddr <= next_raddr;
			dst   <= next_dst;
			data  <= next_data;
			done  <= next_done;
		end
	end

	// Read port and buffered write path.
	assign busy     = (state != S_IDLE);
	assign rd_valid = (state == S_IDXR) || (state == S_SRCR);
	assign rd_addr  = raddr;
	assign f_in     = '{rf: is_sc && c.subop[vsg_pkg::G_RFILE], half: half, addr: dst, data: data}; // see (R14)

	vsg_fifo #(
		.W     ($bits(vsg_pkg::wr_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (state == S_PUSH),
		.in_ready  (f_ready),
		.in_data   (f_in),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_scatter_dst;
		@(posedge core_clk) disable iff (!rst_n)
		(state == S_ELEM && is_sc) |=> (dst == c.reg_c[47:0] + ($past(idx) << esh) + (48'($past(k)) << esh));
	endproperty
	a_scatter_dst: assert property (p_scatter_dst) else $error("scatter address wrong"); // see (R1)

	property p_gather_dst;
		@(posedge core_clk) disable iff (!rst_n)
		(state == S_ELEM && is_ga) |=> (dst == c.reg_c[47:0] + (48'(outn) << esh));
	endproperty
	a_gather_dst: assert property (p_gather_dst) else $error("gather result not consecutive"); // see (R2)

	property p_idx_addr;
		@(posedge core_clk) disable iff (!rst_n)
		(state == S_IDXR) |-> (rd_addr == c.reg_a[47:0] + (48'(grp) << 6));
	endproperty
	a_idx_addr: assert property (p_idx_addr) else $error("index element address wrong"); // see (R3)

	property p_shift;
		@(posedge core_clk) disable iff (!rst_n)
		busy |-> (esh == (c.subop[0] ? 3'h5 : 3'h6));
	endproperty
	a_shift: assert property (p_shift) else $error("item count shift wrong"); // see (R4)

	property p_fixed;
		@(posedge core_clk) disable iff (!rst_n)
		(state == S_ELEM && !is_rv && c.subop[5]) |-> (idx == 48'(c.reg_a[47:0] * grp));
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed increment wrong"); // see (R5)

	property p_single;
		@(posedge core_clk) disable iff (!rst_n)
		(busy && !c.subop[6]) |-> (k == 16'h0000);
	endproperty
	a_single: assert property (p_single) else $error("group larger than one"); // see (R9)

	property p_noop;
		@(posedge core_clk) disable iff (!rst_n)
		(state == S_IDLE && start && cmd.op == 8'hB7 && cmd.subop[6] && cmd.reg_c[63:48] == 16'h0000)
		|=> (state == S_DRN) ##[1:20] done;
	endproperty
	a_noop: assert property (p_noop) else $error("empty group not a no-op"); // see (R10)

	property p_bcast;
		@(posedge core_clk) disable iff (!rst_n)
		(state == S_PUSH && is_ga) |-> $past(state) != S_ELEM;
	endproperty
	a_bcast: assert property (p_bcast) else $error("gather broadcast"); // see (R16)

	property p_zero;
		@(posedge core_clk) disable iff (!rst_n)
		(state == S_ELEM && is_rv && grp >= la) |=> (state == S_PUSH && data == 64'h0);
	endproperty
	a_zero: assert property (p_zero) else $error("reverse fill not zero"); // see (R18)

	property p_done;
		@(posedge core_clk) disable iff (!rst_n)
		done |-> (!wr_valid && $past(state) == S_DRN);
	endproperty
	a_done: assert property (p_done) else $error("done before writes drained"); // see (R21)
endmodule : vector_scatter_gather

// File: vsg_mem.sv
`timescale 1ns/1ps
// ----------------------------------------
// Memory on the far side of the engine
// ----------------------------------------
module vsg_mem (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         slow,
	input  wire logic         wr_hold,
	input  wire logic         rd_valid,
	input  wire logic [47:0]  rd_addr,
	output logic              rd_ready,
	output logic              rvalid,
	output logic [63:0]       rdata,
	input  wire logic         wr_valid,
	output logic              wr_ready,
	input  wire vsg_pkg::wr_t wr
);
	logic [63:0]  mem [logic [47:0]];
	vsg_pkg::wr_t wq [$];
	logic [47:0]  paddr;
	int           pend;
	int           cnt;

	// Outputs are defined before the first edge.
	initial begin
		rd_ready = 1'b0;
		rvalid = 1'b0;
		rdata = 64'h0;
		wr_ready = 1'b0;
		pend = 0;
		cnt = 0;
	end

	// One read at a time, answered late when slow; stale read data is inverted each cycle.
	always @(posedge core_clk) begin
		cnt      <= cnt + 1;
		rvalid   <= 1'b0;
		rdata    <= ~rdata;
		rd_ready <= !slow || cnt[0];
		wr_ready <= !wr_hold && (!slow || cnt[1]);
		if (!rst_n) begin
			pend <= 0;
		end else if (pend == 0 && rd_valid && rd_ready) begin
			paddr <= rd_addr;
			pend  <= slow ? 4 : 1;
		end else if (pend == 1) begin
			rvalid <= 1'b1;
			rdata  <= mem.exists(paddr) ? mem[paddr] : {16'hC3C3, paddr};
			pend   <= 0;
		end else if (pend > 1) begin
			pend <= pend - 1;
		end
		if (rst_n && wr_valid && wr_ready) begin
			wq.push_back(wr);
		end
	end
endmodule : vsg_mem

// File: tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the engine
// ----------------------------------------
module tb_top;
	logic          core_clk;
	logic          rst_n;
	logic          start;
	vsg_pkg::cmd_t cmd;
	logic          busy;
	logic          done;
	logic          rd_valid;
	logic          rd_ready;
	logic [47:0]   rd_addr;
	logic          rvalid;
	logic [63:0]   rdata;
	logic          wr_valid;
	logic          wr_ready;
	vsg_pkg::wr_t  wr;
	logic          slow;
	logic          wr_hold;
	vsg_pkg::wr_t  exp_q [$];
	int            miscompares;
	int            checked;

	vector_scatter_gather #(.DEPTH(8)) i_vector_scatter_gather (.core_clk(core_clk), .rst_n(rst_n),
		.start(start), .cmd(cmd), .busy(busy), .done(done), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_addr(rd_addr), .rvalid(rvalid), .rdata(rdata), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr));

	vsg_mem i_vsg_mem (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .wr_hold(wr_hold),
		.rd_valid(rd_valid), .rd_addr(rd_addr), .rd_ready(rd_ready), .rvalid(rvalid), .rdata(rdata),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr));

	// Free-running clock.
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Default memory contents for addresses not preloaded.
	function automatic logic [63:0] mv(input logic [47:0] a);
		return {16'hC3C3, a};
	endfunction : mv

	task automatic check(input logic [127:0] seen, input logic [127:0] want);
		checked++;
		if (seen !== want) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic ex(input logic rf, input logic h, input logic [47:0] ad, input logic [63:0] d);
		exp_q.push_back('{rf, h, ad, d});
	endtask : ex

	task automatic results;
		$display("miscompares=%0d checked=%0d", miscompares, checked);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// Issues one instruction, optionally stalls writes, then compares the logged writes.
	task automatic run(input logic [7:0] op, input logic [7:0] sub, input logic [63:0] a,
			input logic [63:0] b, input logic [63:0] c, input int hold);
		int n;
		@(posedge core_clk);
		start   <= 1'b1;
		cmd     <= '{op, sub, a, b, c};
		wr_hold <= hold > 0;
		@(posedge core_clk);
		start <= 1'b0;
		repeat (hold) @(posedge core_clk);
		#1;
		if (hold > 0) begin
			check({wr_valid, busy, done}, 3'h6);
			wr_hold = 1'b0;
		end
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 3000) begin
			miscompares++;
			results();
		end
		check(busy, 1'b0);
		check(i_vsg_mem.wq.size(), exp_q.size());
		foreach (exp_q[i]) begin
			if (i < i_vsg_mem.wq.size()) begin
				check(i_vsg_mem.wq[i], exp_q[i]);
			end
		end
		exp_q.delete();
		i_vsg_mem.wq.delete();
	endtask : run

	task automatic t_scatter_idx;
		i_vsg_mem.mem[48'h1000] = 64'hFFFF_0000_0000_0003;
		i_vsg_mem.mem[48'h1040] = 64'h0000_0000_0000_0005;
		ex(1'b0, 1'b0, 48'h100C0, mv(48'h2000));
		ex(1'b0, 1'b0, 48'h10140, mv(48'h2040));
		run(vsg_pkg::SCATTER_OPCODE, 8'h00, {16'h0002, 48'h1000}, 64'h2000, {16'h0007, 48'h10000}, 0);
	endtask : t_scatter_idx

	task automatic t_scatter_inc;
		for (int j = 0; j < 2; j++) begin
			for (int k = 0; k < 2; k++) begin
				ex(1'b0, 1'b1, 48'h8000 + 48'(j * 128 + k * 32), {32'h0, 32'h3000 + 32'((j * 2 + k) * 32)});
			end
		end
		run(vsg_pkg::SCATTER_OPCODE, 8'h61, {16'h0002, 48'h4}, 64'h3000, {16'h0002, 48'h8000}, 0);
	endtask : t_scatter_inc

	task automatic t_bcast;
		for (int j = 0; j < 3; j++) begin
			ex(1'b1, 1'b0, 48'h100 + 48'(j * 128), 64'h1234_5678_9ABC_DEF0);
		end
		run(vsg_pkg::SCATTER_OPCODE, 8'hB0, {16'h0003, 48'h2}, 64'h1234_5678_9ABC_DEF0, {16'h0009, 48'h100}, 0);
	endtask : t_bcast

	task automatic t_noop;
		run(vsg_pkg::SCATTER_OPCODE, 8'h40, {16'h0002, 48'h1000}, 64'h2000, {16'h0000, 48'h9000}, 0);
	endtask : t_noop

	task automatic t_gather;
		slow = 1'b1;
		for (int i = 0; i < 2; i++) begin
			for (int k = 0; k < 2; k++) begin
				ex(1'b0, 1'b0, 48'h20000 + 48'((i * 2 + k) * 64), mv(48'h2000 + 48'(((i ? 5 : 3) + k) * 64)));
			end
		end
		run(vsg_pkg::GATHER_OPCODE, 8'h40, {16'h0002, 48'h1000}, {16'h0002, 48'h2000}, 64'h20000, 0);
		slow = 1'b0;
	endtask : t_gather

	task automatic t_reverse;
		for (int k = 0; k < 5; k++) begin
			ex(1'b0, 1'b0, 48'h5000 + 48'(k * 64), k < 3 ? mv(48'h4000 + 48'((2 - k) * 64)) : 64'h0);
		end
		run(vsg_pkg::REVERSE_COPY_OPCODE, 8'h00, {16'h0003, 48'h4000}, 64'h0, {16'h0005, 48'h5000}, 0);
	endtask : t_reverse

	task automatic t_fill;
		for (int k = 0; k < 10; k++) begin
			ex(1'b0, 1'b0, 48'h6000 + 48'(k * 64), 64'h0);
		end
		run(vsg_pkg::REVERSE_COPY_OPCODE, 8'h00, {16'h0000, 48'h7000}, 64'h0, {16'h000A, 48'h6000}, 40);
	endtask : t_fill

	// Reset, then every scenario in turn.
	initial begin
		miscompares = 0;
		checked = 0;
		rst_n = 1'b0;
		start = 1'b0;
		cmd = '0;
		slow = 1'b0;
		wr_hold = 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		check({busy, done, rd_valid, wr_valid}, 4'h0);
		@(posedge core_clk);
		rst_n <= 1'b1;
		t_scatter_idx();
		t_scatter_inc();
		t_bcast();
		t_noop();
		t_gather();
		t_reverse();
		t_fill();
		results();
	end
endmodule : tb_top
